// ==== hw/ubrp_defines.svh ====
// Constants of the host buffer RAM access port: command codes,
// reset values and pointer step.
// Assumes inclusion by bare name from the package and the port module.
`ifndef UBRP_DEFINES_SVH
`define UBRP_DEFINES_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define UBRP_CMD_RD_ISO1_LEN 8'h2E
`define UBRP_CMD_RD_ISO0_LEN 8'h2C
`define UBRP_CMD_RD_ISO_PORT 8'h40
`define UBRP_CMD_WR_ISO_PORT 8'hC0
`define UBRP_CMD_RD_ACK_PORT 8'h41
`define UBRP_CMD_WR_ACK_PORT 8'hC1

// ****************************************************************
// Reset values and pointer step
// ****************************************************************
`define UBRP_RST_WORD        16'h0000
`define UBRP_RST_CMD         8'h00
`define UBRP_PTR_STEP        16'h0002

`endif

// ==== hw/ubrp_pkg.sv ====
// Types of the host buffer RAM access port.
// Assumes the constants header is on the include path.
`include "ubrp_defines.svh"

package ubrp_pkg;

    // ************************************************************
    // Selection made by the last command
    // ************************************************************
    typedef enum logic [2:0] {
        UBRP_SEL_NONE   = 3'b000,
        UBRP_SEL_ISO_RD = 3'b001,
        UBRP_SEL_ISO_WR = 3'b010,
        UBRP_SEL_ACK_RD = 3'b011,
        UBRP_SEL_ACK_WR = 3'b100,
        UBRP_SEL_LEN0   = 3'b101,
        UBRP_SEL_LEN1   = 3'b110
    } ubrp_sel_e;

    // ************************************************************
    // Buffer RAM request, word = {even byte, odd byte}
    // ************************************************************
    typedef struct packed {
        logic        req;
        logic        we;
        logic        ack_list;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ubrp_ram_req_s;

endpackage

// ==== hw/ubrp_port.sv ====
// Processor access path into the host buffer RAM: command decode,
// read-back length registers, word ports with auto-increment pointer.
// Assumes processor strobes and RAM are on clk_in; RAM answers in the
// cycle of the request, word ordered {even byte, odd byte}.
//
// Behaviour
// - Command 2E reads the 16-bit byte count of isochronous half 1.
// - A 16-bit read-only register gives the half 0 byte count.
// - Iso port: command 40 reads, C0 writes, one word per access.
// - Iso port: upper byte is even address, lower byte odd address.
// - Each word access adds two to pointer, stopping at the counter.
// - Reaching the counter raises end-of-transfer and sets done flag.
// - Counter is in bytes; each access moves one 16-bit word.
// - Ack list port: command 41 reads, C1 writes, one word each.
// - Ack list port: lower byte is even address, upper byte odd.
// - Ack list port follows the same pointer and end protocol.
`timescale 1ns/1ps
`default_nettype none

`include "ubrp_defines.svh"

module ubrp_port
    import ubrp_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    // Processor bus
    input  wire logic          cmd_wr_in,
    input  wire logic [7:0]    cmd_in,
    input  wire logic          data_wr_in,
    input  wire logic          data_rd_in,
    input  wire logic [15:0]   wdata_in,
    output logic      [15:0]   rdata_out,
    output logic               rd_valid_out,
    // Engine side counts and status
    input  wire logic [15:0]   transfer_byte_counter_in,
    input  wire logic [15:0]   iso_half0_byte_count_in,
    input  wire logic [15:0]   iso_half1_byte_count_in,
    input  wire logic          done_flag_clr_in,
    output logic               eot_pulse_out,
    output logic               all_transfers_done_flag_out,
    // Buffer RAM
    output ubrp_ram_req_s      ram_req_out,
    input  wire logic [15:0]   ram_rdata_in
);

    // ************************************************************
    // Byte lane order between port word and RAM word
    // ************************************************************
    function automatic logic [15:0] ubrp_lanes(input logic [15:0] w,
                                               input logic        ack);
        ubrp_lanes = ack ? {w[7:0], w[15:8]} : w;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    ubrp_sel_e      sel_ff;
    logic [15:0]    ptr_ff;
    logic           done_ff;
    logic           flag_ff;
    logic           eot_ff;
    ubrp_ram_req_s  req_ff;
    logic           rd_pend_ff;
    logic           rd_ram_ff;
    logic           rd_ack_ff;
    logic [15:0]    rd_hold_ff;
    logic [15:0]    rdata_ff;
    logic           rvalid_ff;

    // ************************************************************
    // Command decode
    // ************************************************************
    ubrp_sel_e      nxt_sel;
    logic           cmd_is_port;

    always_comb begin
        case (cmd_in)
            `UBRP_CMD_RD_ISO_PORT: nxt_sel = UBRP_SEL_ISO_RD;
            `UBRP_CMD_WR_ISO_PORT: nxt_sel = UBRP_SEL_ISO_WR;
            `UBRP_CMD_RD_ACK_PORT: nxt_sel = UBRP_SEL_ACK_RD;
            `UBRP_CMD_WR_ACK_PORT: nxt_sel = UBRP_SEL_ACK_WR;
            `UBRP_CMD_RD_ISO1_LEN: nxt_sel = UBRP_SEL_LEN1;
            `UBRP_CMD_RD_ISO0_LEN: nxt_sel = UBRP_SEL_LEN0;
            default:               nxt_sel = UBRP_SEL_NONE;
        endcase
    end

    assign cmd_is_port = (nxt_sel == UBRP_SEL_ISO_RD) ||
                         (nxt_sel == UBRP_SEL_ISO_WR) ||
                         (nxt_sel == UBRP_SEL_ACK_RD) ||
                         (nxt_sel == UBRP_SEL_ACK_WR);

    // ************************************************************
    // Data access qualification
    // ************************************************************
    wire logic sel_ack   = (sel_ff == UBRP_SEL_ACK_RD) ||
                           (sel_ff == UBRP_SEL_ACK_WR);
    wire logic port_rd   = data_rd_in && !cmd_wr_in &&
                           ((sel_ff == UBRP_SEL_ISO_RD) ||
                            (sel_ff == UBRP_SEL_ACK_RD));
    wire logic port_wr   = data_wr_in && !cmd_wr_in &&
                           ((sel_ff == UBRP_SEL_ISO_WR) ||
                            (sel_ff == UBRP_SEL_ACK_WR));
    // Past the end nothing moves
    wire logic access    = (port_rd || port_wr) && !done_ff;
    wire logic any_rd    = data_rd_in && !cmd_wr_in;

    // Byte pointer, one word per access
    wire logic [15:0] nxt_ptr = ptr_ff + `UBRP_PTR_STEP;
    wire logic        reach   = access &&
                                (nxt_ptr >= transfer_byte_counter_in);

    // Register read-back source for non-RAM reads
    wire logic [15:0] reg_word =
        (sel_ff == UBRP_SEL_LEN1) ? iso_half1_byte_count_in :
        (sel_ff == UBRP_SEL_LEN0) ? iso_half0_byte_count_in :
                                    `UBRP_RST_WORD;

    // ************************************************************
    // Command, pointer and end of transfer
    // ************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_ff  <= UBRP_SEL_NONE;
            ptr_ff  <= `UBRP_RST_WORD;
            done_ff <= 1'b0;
            eot_ff  <= 1'b0;
        end else begin
            eot_ff <= reach;
            if (cmd_wr_in) begin
                sel_ff <= nxt_sel;
                if (cmd_is_port) begin
                    ptr_ff  <= `UBRP_RST_WORD;
                    done_ff <= 1'b0;
                end
            end else if (access) begin
                ptr_ff  <= nxt_ptr;
                done_ff <= reach;
            end
        end
    end

    // Done flag, a new end wins over a clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_ff <= 1'b0;
        end else if (eot_ff) begin
            flag_ff <= 1'b1;
        end else if (done_flag_clr_in) begin
            flag_ff <= 1'b0;
        end
    end

    // ************************************************************
    // RAM request
    // ************************************************************
    ubrp_ram_req_s nxt_req;

    always_comb begin
        nxt_req          = '0;
        nxt_req.req      = access;
        nxt_req.we       = port_wr;
        nxt_req.ack_list = sel_ack;
        nxt_req.addr     = ptr_ff;
        nxt_req.wdata    = ubrp_lanes(wdata_in, sel_ack);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_ff <= '0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // ************************************************************
    // Read pipeline, answer two cycles after the strobe
    // ************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_pend_ff <= 1'b0;
            rd_ram_ff  <= 1'b0;
            rd_ack_ff  <= 1'b0;
            rd_hold_ff <= `UBRP_RST_WORD;
        end else begin
            rd_pend_ff <= any_rd;
            rd_ram_ff  <= port_rd && !done_ff;
            rd_ack_ff  <= sel_ack;
            rd_hold_ff <= reg_word;
        end
    end

    wire logic [15:0] ram_word = ubrp_lanes(ram_rdata_in, rd_ack_ff);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff  <= `UBRP_RST_WORD;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= rd_pend_ff;
            if (rd_pend_ff) begin
                rdata_ff <= rd_ram_ff ? ram_word : rd_hold_ff;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdata_out                   = rdata_ff;
    assign rd_valid_out                = rvalid_ff;
    assign eot_pulse_out               = eot_ff;
    assign all_transfers_done_flag_out = flag_ff;
    assign ram_req_out                 = req_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    a_ptr_step_two: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        access |=> (ptr_ff == $past(ptr_ff) + `UBRP_PTR_STEP))
        else $error("pointer did not advance by two");

    a_cmd_restart: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (cmd_wr_in && cmd_is_port) |=> (ptr_ff == 16'h0000 && !done_ff))
        else $error("port command did not restart pointer");

    a_no_move_done: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (done_ff && !cmd_wr_in) |=> $stable(ptr_ff) && !eot_ff)
        else $error("pointer moved after end of transfer");

    a_eot_at_count: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        eot_ff |-> done_ff &&
        (ptr_ff >= $past(transfer_byte_counter_in)))
        else $error("end of transfer without reaching counter");

    a_eot_one_shot: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        eot_ff |=> !eot_ff)
        else $error("end of transfer repeated");

    a_flag_sets: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        eot_ff |=> flag_ff)
        else $error("done flag not set by end of transfer");

    a_len1_read: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (any_rd && sel_ff == UBRP_SEL_LEN1) |=> ##1
        (rvalid_ff && rdata_ff == $past(iso_half1_byte_count_in, 2)))
        else $error("half 1 length read wrong");

    a_len0_read: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (any_rd && sel_ff == UBRP_SEL_LEN0) |-> ##2
        (rvalid_ff && rdata_ff == $past(iso_half0_byte_count_in, 2)))
        else $error("half 0 length read wrong");

    a_iso_wr_lanes: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (access && port_wr && !sel_ack) |=>
        (req_ff.req && req_ff.we && req_ff.wdata == $past(wdata_in)))
        else $error("iso write lane order wrong");

    a_ack_wr_lanes: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (access && port_wr && sel_ack) |=> (req_ff.req &&
        req_ff.wdata == {$past(wdata_in[7:0]), $past(wdata_in[15:8])}))
        else $error("ack list write lane order wrong");

    a_req_at_ptr: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        access |=> (req_ff.req && req_ff.addr == $past(ptr_ff)))
        else $error("RAM request not at pointer");

    a_rd_answer: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        any_rd |-> ##2 rvalid_ff)
        else $error("read strobe not answered");

    a_iso_rd_lanes: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (rd_ram_ff && !rd_ack_ff) |=> (rdata_ff == $past(ram_rdata_in)))
        else $error("iso read lane order wrong");

    a_ack_rd_lanes: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (rd_ram_ff && rd_ack_ff) |=> (rdata_ff ==
        {$past(ram_rdata_in[7:0]), $past(ram_rdata_in[15:8])}))
        else $error("ack list read lane order wrong");

    a_flag_clears: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (done_flag_clr_in && !eot_ff) |=> !flag_ff)
        else $error("done flag not cleared");

endmodule

`default_nettype wire

// ==== bench/ubrp_ram_model.sv ====
// Behavioural buffer RAM behind the host buffer RAM access port.
// Assumes the port's request struct on clk_in; answers reads in the
// cycle of the request, word ordered {even byte, odd byte}.
`timescale 1ns/1ps
`default_nettype none

module ubrp_ram_model
    import ubrp_pkg::*;
(
    // Clock
    input  wire logic          clk_in,
    // Request and answer
    input  wire ubrp_ram_req_s req_in,
    output logic      [15:0]   rdata_out
);
    logic [15:0] mem_iso [0:63];
    logic [15:0] mem_ack [0:63];
    logic [15:0] last_ff = 16'h0000;
    wire  [5:0]  idx     = req_in.addr[6:1];
    wire         rd_now  = req_in.req && !req_in.we;
    wire  [15:0] word    = req_in.ack_list ? mem_ack[idx] : mem_iso[idx];

    // Outside a read the data lines show no stale word
    assign rdata_out = rd_now ? word : ~last_ff;

    always @(posedge clk_in) begin
        if (req_in.req && req_in.we && req_in.ack_list) begin
            mem_ack[idx] <= req_in.wdata;
        end
        if (req_in.req && req_in.we && !req_in.ack_list) begin
            mem_iso[idx] <= req_in.wdata;
        end
        if (rd_now) begin
            last_ff <= word;
        end
    end
endmodule

`default_nettype wire

// ==== bench/ubrp_port_tb.sv ====
// Self-checking bench of the host buffer RAM access port.
// Assumes the package and the RAM model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`include "ubrp_defines.svh"

module ubrp_port_tb
    import ubrp_pkg::*;
;
    logic          clk_in = 1'b0;
    logic          rst_n_in = 1'b0;
    logic          cmd_wr_in = 1'b0;
    logic [7:0]    cmd_in = 8'h00;
    logic          data_wr_in = 1'b0;
    logic          data_rd_in = 1'b0;
    logic [15:0]   wdata_in = 16'h0000;
    logic [15:0]   transfer_byte_counter_in = 16'h0000;
    logic [15:0]   iso_half0_byte_count_in = 16'hABCD;
    logic [15:0]   iso_half1_byte_count_in = 16'h0006;
    logic          done_flag_clr_in = 1'b0;
    logic [15:0]   rdata_out;
    logic          rd_valid_out;
    logic          eot_pulse_out;
    logic          all_transfers_done_flag_out;
    ubrp_ram_req_s ram_req_out;
    logic [15:0]   ram_rdata_in;
    logic [15:0]   rd_q[$];
    int            bad_count = 0;
    int            n_compared = 0;
    int            eot_n = 0;
    int            req_n = 0;
    int            cycles = 0;

    ubrp_port u_ubrp_port (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .cmd_wr_in(cmd_wr_in), .cmd_in(cmd_in), .data_wr_in(data_wr_in),
        .data_rd_in(data_rd_in), .wdata_in(wdata_in),
        .rdata_out(rdata_out), .rd_valid_out(rd_valid_out),
        .transfer_byte_counter_in(transfer_byte_counter_in),
        .iso_half0_byte_count_in(iso_half0_byte_count_in),
        .iso_half1_byte_count_in(iso_half1_byte_count_in),
        .done_flag_clr_in(done_flag_clr_in), .eot_pulse_out(eot_pulse_out),
        .all_transfers_done_flag_out(all_transfers_done_flag_out),
        .ram_req_out(ram_req_out), .ram_rdata_in(ram_rdata_in));

    ubrp_ram_model u_ubrp_ram_model (.clk_in(clk_in),
        .req_in(ram_req_out), .rdata_out(ram_rdata_in));

    // ************************************************************
    // Clock, monitors and hang guard
    // ************************************************************
    always #25 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (rd_valid_out === 1'b1) rd_q.push_back(rdata_out);
        if (eot_pulse_out === 1'b1) eot_n++;
        if (ram_req_out.req === 1'b1) req_n++;
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send_cmd(input logic [7:0] code);
        @(negedge clk_in);
        cmd_wr_in = 1'b1;
        cmd_in    = code;
        @(negedge clk_in);
        cmd_wr_in = 1'b0;
    endtask

    // Back-to-back word writes, one per cycle
    task automatic put_words(input logic [15:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in);
            data_wr_in = 1'b1;
            wdata_in   = base + 16'(i) * 16'h0101;
        end
        @(negedge clk_in);
        data_wr_in = 1'b0;
    endtask

    // Back-to-back reads; words past m answer zero
    task automatic get_words(input logic [15:0] base, input int n,
                             input int m);
        rd_q.delete();
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in);
            data_rd_in = 1'b1;
        end
        @(negedge clk_in);
        data_rd_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk("read answers", 16'(rd_q.size()), 16'(n));
        for (int i = 0; i < n && i < rd_q.size(); i++) begin
            chk("read word", rd_q[i], i < m ? base + 16'(i) * 16'h0101
                                            : 16'h0000);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        chk("rdata after reset", rdata_out, `UBRP_RST_WORD);
        chk("flags after reset", {14'h0, eot_pulse_out,
            all_transfers_done_flag_out}, 16'h0000);
        send_cmd(`UBRP_CMD_RD_ISO1_LEN);
        get_words(16'h0006, 1, 1);
        send_cmd(`UBRP_CMD_RD_ISO0_LEN);
        get_words(16'hABCD, 1, 1);
        send_cmd(8'h55);
        get_words(16'h0000, 1, 0);
        // Counter loaded before the command, command given once
        transfer_byte_counter_in = iso_half1_byte_count_in;
        send_cmd(`UBRP_CMD_WR_ISO_PORT);
        put_words(16'h1234, 4);
        repeat (2) @(negedge clk_in);
        chk("iso write requests", 16'(req_n), 16'h0003);
        chk("eot after iso write", 16'(eot_n), 16'h0001);
        chk("done flag", {15'h0, all_transfers_done_flag_out}, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            chk("iso ram word", u_ubrp_ram_model.mem_iso[i],
                16'h1234 + 16'(i) * 16'h0101);
        end
        send_cmd(`UBRP_CMD_RD_ISO_PORT);
        get_words(16'h1234, 4, 3);
        chk("eot after iso read", 16'(eot_n), 16'h0002);
        @(negedge clk_in);
        done_flag_clr_in = 1'b1;
        @(negedge clk_in);
        done_flag_clr_in = 1'b0;
        @(negedge clk_in);
        chk("flag cleared", {15'h0, all_transfers_done_flag_out}, 16'h0000);
        transfer_byte_counter_in = 16'h0004;
        send_cmd(`UBRP_CMD_WR_ACK_PORT);
        put_words(16'hA1B2, 2);
        repeat (2) @(negedge clk_in);
        for (int i = 0; i < 2; i++) begin
            wdata_in = 16'hA1B2 + 16'(i) * 16'h0101;
            chk("ack ram word", u_ubrp_ram_model.mem_ack[i],
                {wdata_in[7:0], wdata_in[15:8]});
        end
        chk("eot after ack write", 16'(eot_n), 16'h0003);
        chk("done flag ack", {15'h0, all_transfers_done_flag_out}, 16'h0001);
        send_cmd(`UBRP_CMD_RD_ACK_PORT);
        get_words(16'hA1B2, 3, 2);
        chk("ack requests", 16'(req_n), 16'h000A);
        chk("eot after ack read", 16'(eot_n), 16'h0004);
        stop_test();
    end
endmodule

`default_nettype wire
